// ===== logic/ascii_serial_command_framer.v
`timescale 1ns/100ps
`include "serial_framer_consts.vh"

module ascii_serial_command_framer #(
  parameter [7:0]  RESET_ADDR = `DEF_ADDR,
  parameter [11:0] BIT_CYC    = `BIT_CYCLES,
  parameter [11:0] HALF_CYC   = `HALF_CYCLES
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        rxd,
  output wire        txd,
  output wire        tx_drive_en,
  input  wire        setup_jumper_pin_a,
  output wire        setup_jumper_pin_b,
  output reg         wr_stb,
  output reg         rd_req,
  output reg  [7:0]  cmd_code_field,
  output reg  [31:0] value_field,
  input  wire        rd_ack,
  input  wire [31:0] rd_value,
  output wire [7:0]  unit_addr_field
);

  // ==========================================================
  // Character helpers
  // [RL1] lowercase hex decode
  function [4:0] hex_dec;
    input [7:0] c;
    begin
      if (c >= `CH_DIG0 && c <= `CH_DIG9) begin
        hex_dec = {1'b1, c[3:0]};
      end else if (c >= `CH_LETA && c <= `CH_LETF) begin
        hex_dec = {1'b1, c[3:0] + 4'h9};
      end else begin
        hex_dec = 5'h00;
      end
    end
  endfunction

  // [RL9] lowercase hex encode
  function [7:0] hex_enc;
    input [3:0] n;
    begin
      if (n > 4'h9) begin
        hex_enc = {4'h0, n} + `LET_OFS;
      end else begin
        hex_enc = {4'h0, n} + `CH_DIG0;
      end
    end
  endfunction

  // ==========================================================
  // Setup jumper and own address
  reg        strap_taken_ff;
  reg        setup_mode_ff;
  reg  [7:0] addr_ff;
  wire [7:0] own_addr = setup_mode_ff ? `SETUP_ADDR : addr_ff;

  // Pin b is held low so a fitted jumper pulls pin a low
  assign setup_jumper_pin_b = 1'b0;
  assign unit_addr_field    = own_addr;

  // [RL17] strap caught after reset
  always @(posedge mclk) begin
    if (rst) begin
      strap_taken_ff <= 1'b0;
      setup_mode_ff  <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      setup_mode_ff  <= ~setup_jumper_pin_a;
    end
  end

  // ==========================================================
  // Receiver
  // [RL19] 8N1 at the link rate
  reg  [11:0] rx_cnt_ff;
  reg  [3:0]  rx_bit_ff;
  reg  [7:0]  rx_sh_ff;
  reg         rx_busy_ff;
  reg         rx_stb_ff;
  reg  [7:0]  rx_byte_ff;

  always @(posedge mclk) begin
    if (rst) begin
      rx_cnt_ff  <= 12'h000;
      rx_bit_ff  <= 4'h0;
      rx_sh_ff   <= 8'h00;
      rx_busy_ff <= 1'b0;
      rx_stb_ff  <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_stb_ff <= 1'b0;
      if (!rx_busy_ff) begin
        if (!rxd) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff  <= HALF_CYC;
          rx_bit_ff  <= 4'h0;
        end
      end else if (rx_cnt_ff != 12'h000) begin
        rx_cnt_ff <= rx_cnt_ff - 12'h001;
      end else begin
        rx_cnt_ff <= BIT_CYC - 12'h001;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0) begin
          // Glitch on the line rather than a real start bit
          if (rxd) begin
            rx_busy_ff <= 1'b0;
          end
        end else if (rx_bit_ff <= `RX_DATA_BITS) begin
          rx_sh_ff <= {rxd, rx_sh_ff[7:1]};
        end else begin
          rx_busy_ff <= 1'b0;
          // A framing error drops the character
          if (rxd) begin
            rx_stb_ff  <= 1'b1;
            rx_byte_ff <= rx_sh_ff;
          end
        end
      end
    end
  end

  // ==========================================================
  // Frame parser
  localparam P_HUNT = 1'b0;
  localparam P_BODY = 1'b1;

  reg         pstate_ff;
  reg  [3:0]  pcnt_ff;
  reg  [55:0] nib_ff;
  reg  [7:0]  acc_ff;
  reg  [7:0]  lag1_ff;
  reg  [7:0]  lag2_ff;
  reg         frame_ff;
  wire [4:0]  dec = hex_dec(rx_byte_ff);

  always @(posedge mclk) begin
    if (rst) begin
      pstate_ff <= P_HUNT;
      pcnt_ff   <= 4'h0;
      nib_ff    <= 56'h0;
      acc_ff    <= 8'h00;
      lag1_ff   <= 8'h00;
      lag2_ff   <= 8'h00;
      frame_ff  <= 1'b0;
    end else begin
      frame_ff <= 1'b0;
      if (rx_stb_ff) begin
        // [RL2] [RL24] start restarts
        if (rx_byte_ff == `CH_START) begin
          pstate_ff <= P_BODY;
          pcnt_ff   <= 4'h0;
          acc_ff    <= 8'h00;
          lag1_ff   <= 8'h00;
          lag2_ff   <= 8'h00;
        end else if (pstate_ff == P_BODY) begin
          // [RL3] [RL25] terminator and length
          if (rx_byte_ff == `CH_CR) begin
            pstate_ff <= P_HUNT;
            frame_ff  <= (pcnt_ff == `LEN_WRITE) || (pcnt_ff == `LEN_QUERY);
          end else if (!dec[4] || pcnt_ff == `LEN_WRITE) begin
            // [RL24] bad character or overlong
            pstate_ff <= P_HUNT;
          end else begin
            // [RL10] lags drop the checksum digits
            pcnt_ff <= pcnt_ff + 4'h1;
            nib_ff  <= {nib_ff[51:0], dec[3:0]};
            acc_ff  <= acc_ff + rx_byte_ff;
            lag1_ff <= acc_ff;
            lag2_ff <= lag1_ff;
          end
        end
      end
    end
  end

  // [RL5] [RL6] [RL12] [RL14] field positions
  wire        is_write = (pcnt_ff == `LEN_WRITE);
  wire [7:0]  f_addr   = is_write ? nib_ff[55:48] : nib_ff[23:16];
  wire [7:0]  f_cmd    = is_write ? nib_ff[47:40] : nib_ff[15:8];
  // [RL8] send value
  wire [31:0] f_data   = nib_ff[39:8];
  // [RL7] [RL18] address match
  wire        addr_hit = (f_addr == `UNIV_ADDR) || (f_addr == own_addr);
  // [RL11] checksum compare
  wire        sum_ok   = (nib_ff[7:0] == lag2_ff);

  // ==========================================================
  // Command control and response
  localparam C_IDLE  = 2'h0;
  localparam C_QWAIT = 2'h1;
  localparam C_SEND  = 2'h2;

  reg  [1:0]  cstate_ff;
  reg  [31:0] resp_ff;
  reg         err_ff;
  reg  [3:0]  idx_ff;
  reg  [7:0]  tsum_ff;
  reg         tx_start_ff;
  reg  [7:0]  tx_byte_ff;
  reg         tx_busy_ff;
  reg  [9:0]  tx_sh_ff;
  reg  [3:0]  tx_bits_ff;
  reg  [11:0] tx_cnt_ff;
  reg  [7:0]  ch;

  // Response character at the current index
  always @* begin
    if (idx_ff == 4'h0) begin
      ch = `CH_START;
    end else if (idx_ff <= `LAST_DIG) begin
      // [RL16] error digits
      ch = err_ff ? `CH_ERR : hex_enc(resp_ff[31:28]);
    end else if (idx_ff == `SUM_HI_IDX) begin
      ch = hex_enc(tsum_ff[7:4]);
    end else if (idx_ff == `SUM_LO_IDX) begin
      ch = hex_enc(tsum_ff[3:0]);
    end else begin
      // [RL4] caret terminator
      ch = `CH_ACK;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      cstate_ff      <= C_IDLE;
      resp_ff        <= 32'h0;
      err_ff         <= 1'b0;
      idx_ff         <= 4'h0;
      tsum_ff        <= 8'h00;
      tx_start_ff    <= 1'b0;
      tx_byte_ff     <= 8'h00;
      addr_ff        <= RESET_ADDR;
      wr_stb         <= 1'b0;
      rd_req         <= 1'b0;
      cmd_code_field <= 8'h00;
      value_field    <= 32'h0;
    end else begin
      wr_stb      <= 1'b0;
      tx_start_ff <= 1'b0;
      case (cstate_ff)
        C_IDLE: begin
          // Frames that finish while a reply is pending are dropped
          if (frame_ff && addr_hit) begin
            idx_ff         <= 4'h0;
            tsum_ff        <= 8'h00;
            err_ff         <= ~sum_ok;
            cmd_code_field <= f_cmd;
            if (!sum_ok) begin
              cstate_ff <= C_SEND;
            end else if (is_write) begin
              // [RL13] echo send value
              resp_ff     <= f_data;
              value_field <= f_data;
              cstate_ff   <= C_SEND;
              // [RL23] address write, 63 refused
              // Address commands stay internal, so storage sees no strobe
              if (f_cmd == `CMD_ADDR_WR) begin
                if (f_data[7:0] != `SETUP_ADDR) begin
                  addr_ff <= f_data[7:0];
                end
              end else begin
                wr_stb <= 1'b1;
              end
            end else if (f_cmd == `CMD_ADDR_RD) begin
              // [RL23] address read
              resp_ff   <= {24'h0, own_addr};
              cstate_ff <= C_SEND;
            end else begin
              rd_req    <= 1'b1;
              cstate_ff <= C_QWAIT;
            end
          end
        end
        C_QWAIT: begin
          // [RL15] return value from storage
          // Read data is taken on the answering edge only
          if (rd_ack) begin
            rd_req    <= 1'b0;
            resp_ff   <= rd_value;
            cstate_ff <= C_SEND;
          end
        end
        C_SEND: begin
          if (!tx_busy_ff && !tx_start_ff) begin
            tx_start_ff <= 1'b1;
            tx_byte_ff  <= ch;
            idx_ff      <= idx_ff + 4'h1;
            // [RL9] [RL10] sum value digits only
            if (idx_ff >= `FIRST_DIG && idx_ff <= `LAST_DIG) begin
              tsum_ff <= tsum_ff + ch;
              resp_ff <= {resp_ff[27:0], 4'h0};
            end
            if (idx_ff == `LAST_IDX) begin
              cstate_ff <= C_IDLE;
            end
          end
        end
        default: begin
          cstate_ff <= C_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Transmitter
  // [RL19] 8N1 transmit
  always @(posedge mclk) begin
    if (rst) begin
      tx_busy_ff <= 1'b0;
      tx_sh_ff   <= 10'h3FF;
      tx_bits_ff <= 4'h0;
      tx_cnt_ff  <= 12'h000;
    end else if (tx_start_ff) begin
      tx_busy_ff <= 1'b1;
      tx_sh_ff   <= {1'b1, tx_byte_ff, 1'b0};
      tx_bits_ff <= `UART_BITS;
      tx_cnt_ff  <= BIT_CYC - 12'h001;
    end else if (tx_busy_ff) begin
      if (tx_cnt_ff != 12'h000) begin
        tx_cnt_ff <= tx_cnt_ff - 12'h001;
      end else if (tx_bits_ff == 4'h1) begin
        tx_busy_ff <= 1'b0;
        tx_sh_ff   <= 10'h3FF;
      end else begin
        tx_cnt_ff  <= BIT_CYC - 12'h001;
        tx_bits_ff <= tx_bits_ff - 4'h1;
        tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
      end
    end
  end

  assign txd = tx_sh_ff[0];
  // Driver stays on between characters of one reply to avoid bus turnarounds.
  // The start pulse counts too: the send state ends on the edge that launches
  // the caret, one cycle before the shifter reports busy.
  assign tx_drive_en = tx_busy_ff | tx_start_ff | (cstate_ff == C_SEND);

endmodule

// ===== logic/serial_framer_consts.vh
// Overview of operation
// [RL1] Fields are hex digits; letters a to f only lowercase, both ways.
// [RL2] Every frame in either direction starts with asterisk 0x2A.
// [RL3] Host ends each request with carriage return 0x0D.
// [RL4] Device ends each response with caret 0x5E, never carriage return.
// [RL5] Address field is exactly two hex digits 0-9 or a-f.
// [RL6] Command field is exactly two hex digits 0-9 or a-f.
// [RL7] Address 00 is accepted and answered by every unit.
// [RL8] Value field is eight hex digits of a 32-bit two's-complement number.
// [RL9] Checksum is 8-bit wrapping sum of ASCII codes, sent as two lowercase digits.
// [RL10] Checksum excludes start character, checksum digits and terminator.
// [RL11] Device compares its computed checksum with received digits to pick response.
// [RL12] Write request: start, address, command, eight data digits, checksum, CR.
// [RL13] Good write echoes start, value, checksum of value, caret.
// [RL14] Query request: start, address, command, checksum, CR; no data.
// [RL15] Good query returns start, eight-digit value, its checksum, caret.
// [RL16] Bad checksum reply: start, eight uppercase X, digits c0, caret.
// [RL17] Setup jumper fitted at power-up forces address 0x63 for the session.
// [RL18] No reply to requests addressed to another unit.
// [RL19] Link is 9600 baud, no parity, one start and one stop bit.
// [RL20] Host should leave about one millisecond between characters.
// [RL21] Host pads send values with leading zeros to eight digits.
// [RL22] Host may verify response checksums to detect corruption.
// [RL23] Own address is written by command 2a, read by 43; 63 reserved.
// [RL24] Start character restarts parsing; malformed frames are dropped silently.
// [RL25] Fourteen characters between start and terminator mean write, six mean query.
`ifndef SERIAL_FRAMER_CONSTS_VH
`define SERIAL_FRAMER_CONSTS_VH

`define CH_START     8'h2A
`define CH_CR        8'h0D
`define CH_ACK       8'h5E
`define CH_ERR       8'h58
`define CH_DIG0      8'h30
`define CH_DIG9      8'h39
`define CH_LETA      8'h61
`define CH_LETF      8'h66
`define LET_OFS      8'h57
`define UNIV_ADDR    8'h00
`define SETUP_ADDR   8'h63
`define DEF_ADDR     8'h01
`define CMD_ADDR_WR  8'h2A
`define CMD_ADDR_RD  8'h43
`define LEN_WRITE    4'hE
`define LEN_QUERY    4'h6
`define LAST_IDX     4'hB
`define FIRST_DIG    4'h1
`define LAST_DIG     4'h8
`define SUM_HI_IDX   4'h9
`define SUM_LO_IDX   4'hA
`define UART_BITS    4'hA
`define RX_DATA_BITS 4'h8
`define CLK_HZ       25000000
`define BAUD_RATE    9600
// Clock over baud rate and its half, sized to the 12-bit bit counters
`define BIT_CYCLES   12'hA2C
`define HALF_CYCLES  12'h516

`endif

// ===== tb/framer_chk.sv
`timescale 1ns/100ps
// ====================
// Port checks
module framer_chk (
  input wire mclk,
  input wire rst,
  input wire txd,
  input wire tx_drive_en,
  input wire setup_jumper_pin_b,
  input wire wr_stb,
  input wire rd_req,
  input wire rd_ack
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wr_pulse_a: assert property (wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
  rd_hold_a: assert property (rd_req && !rd_ack |=> rd_req)
    else $error("query dropped before answer");
  rd_drop_a: assert property (rd_req && rd_ack |=> !rd_req)
    else $error("query still pending after answer");
  tx_idle_a: assert property (!tx_drive_en |-> txd)
    else $error("line not idle while driver off");
  start_bit_a: assert property ($rose(tx_drive_en) |-> ##[0:4] !txd)
    else $error("no start bit after driver on");
  jumper_ret_a: assert property (setup_jumper_pin_b == 1'b0)
    else $error("jumper return not low");
  drive_gap_a: assert property ($fell(tx_drive_en) |=> !tx_drive_en)
    else $error("driver enable glitched within a reply");
  one_kind_a: assert property (!(wr_stb && rd_req))
    else $error("write and query at once");
  rst_quiet_a: assert property (disable iff (1'b0) rst |=> txd && !tx_drive_en && !wr_stb && !rd_req)
    else $error("outputs active after reset");
endmodule

bind ascii_serial_command_framer framer_chk u_chk (
  .mclk(mclk), .rst(rst), .txd(txd), .tx_drive_en(tx_drive_en),
  .setup_jumper_pin_b(setup_jumper_pin_b), .wr_stb(wr_stb), .rd_req(rd_req), .rd_ack(rd_ack));

// ===== tb/host_uart.sv
`timescale 1ns/100ps
// ====================
// Host side of the serial link
module host_uart #(
  parameter BIT = 16
) (
  input  wire mclk,
  input  wire txd,
  output reg  rxd
);
  byte        rxq[$];
  logic [7:0] rx_ff;
  initial rxd = 1'b1;

  function automatic string hx(input logic [31:0] v, input int n);
    string s, d;
    s = "";
    d = "0123456789abcdef";
    for (int i = n - 1; i >= 0; i--) s = {s, d.substr(v[i*4+:4], v[i*4+:4])};
    return s;
  endfunction

  function automatic logic [7:0] csum(input string s);
    logic [7:0] a;
    a = 8'h00;
    for (int i = 0; i < s.len(); i++) a = a + s[i];
    return a;
  endfunction

  // 8N1 with a gap so the receiver keeps up
  task automatic send_str(input string s);
    logic [7:0] c;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      for (int b = 0; b < 10; b++) begin
        @(posedge mclk);
        rxd <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : c[b-1];
        repeat (BIT - 1) @(posedge mclk);
      end
      repeat (2 * BIT) @(posedge mclk);
    end
  endtask

  task automatic send_req(input logic [7:0] a, input logic [7:0] c, input logic [31:0] v,
                          input bit wr, input bit bad);
    string body;
    body = {hx(a, 2), hx(c, 2), wr ? hx(v, 8) : ""};
    send_str({"*", body, hx(csum(body) + bad, 2), "\r"});
  endtask

  // Collect reply bytes, sampled mid bit
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge mclk);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT) @(posedge mclk);
      rx_ff[b] = txd;
    end
    repeat (BIT) @(posedge mclk);
    rxq.push_back(rx_ff);
  end
endmodule

// ===== tb/test_ascii_serial_command_framer.sv
`timescale 1ns/100ps
// ====================
// Bench
module test_ascii_serial_command_framer;
  reg          mclk = 1'b0;
  reg          rst = 1'b1;
  reg          jumper_n = 1'b1;
  reg          rd_ack = 1'b0;
  reg  [31:0]  rd_value = 32'h00000000;
  wire         rxd, txd, tx_drive_en, setup_jumper_pin_b, wr_stb, rd_req;
  wire [7:0]   cmd_code_field, unit_addr_field;
  wire [31:0]  value_field;
  integer      fails = 0, samples_checked = 0, wr_cnt = 0, rd_cnt = 0;

  always #20 mclk = ~mclk;

  // Small bit time keeps the run short
  ascii_serial_command_framer #(.BIT_CYC(12'h010), .HALF_CYC(12'h008)) u_dut (
    .mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en),
    .setup_jumper_pin_a(jumper_n), .setup_jumper_pin_b(setup_jumper_pin_b),
    .wr_stb(wr_stb), .rd_req(rd_req), .cmd_code_field(cmd_code_field),
    .value_field(value_field), .rd_ack(rd_ack), .rd_value(rd_value),
    .unit_addr_field(unit_addr_field));
  host_uart #(.BIT(16)) u_host (.mclk(mclk), .txd(txd), .rxd(rxd));

  // Storage answers one cycle after each query; its value stands only with the answer
  always @(posedge mclk) begin
    rd_ack <= rd_req & ~rd_ack;
    rd_value <= (rd_req & ~rd_ack) ? 32'hFFFFFFFF : 32'h00000000;
    if (rd_req === 1'b1 && rd_ack === 1'b0) rd_cnt <= rd_cnt + 1;
    if (wr_stb === 1'b1) wr_cnt <= wr_cnt + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic get_reply(input string exp);
    int  n;
    byte c;
    n = 0;
    for (int w = 0; w < 8000 && u_host.rxq.size() < exp.len(); w++) @(posedge mclk);
    check("reply length", u_host.rxq.size(), exp.len());
    while (u_host.rxq.size() > 0) begin
      c = u_host.rxq.pop_front();
      if (n < exp.len()) check("reply char", c, exp[n]);
      n++;
    end
  endtask

  task automatic do_reset(input bit jmp);
    @(posedge mclk);
    rst <= 1'b1;
    jumper_n <= ~jmp;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic t_write;
    u_host.send_req(8'h01, 8'h1C, 32'h000003E8, 1, 0);
    get_reply("*000003e8c0^");
    check("write strobes", wr_cnt, 1);
    check("command", cmd_code_field, 8'h1C);
    check("value", value_field, 32'h000003E8);
  endtask

  task automatic t_query;
    u_host.send_req(8'h00, 8'h01, 32'h0, 0, 0);
    get_reply("*ffffffff30^");
    check("queries", rd_cnt, 1);
    check("query command", cmd_code_field, 8'h01);
  endtask

  task automatic t_bad;
    u_host.send_req(8'h01, 8'h1C, 32'h00000005, 1, 1);
    get_reply("*XXXXXXXXc0^");
    check("no write on bad sum", wr_cnt, 1);
  endtask

  task automatic t_other;
    u_host.send_req(8'h05, 8'h01, 32'h0, 0, 0);
    repeat (3000) @(posedge mclk);
    check("silent", u_host.rxq.size(), 0);
    check("no query", rd_cnt, 1);
  endtask

  task automatic t_drop;
    u_host.send_str("*011C000000095e\r");
    repeat (3000) @(posedge mclk);
    check("uppercase dropped", u_host.rxq.size(), 0);
    u_host.send_str("*0101");
    u_host.send_req(8'h01, 8'h1C, 32'h00000007, 1, 0);
    get_reply("*0000000787^");
    check("write after restart", wr_cnt, 2);
  endtask

  task automatic t_addr;
    u_host.send_req(8'h01, 8'h2A, 32'h00000005, 1, 0);
    get_reply("*0000000585^");
    check("own address", unit_addr_field, 8'h05);
    u_host.send_req(8'h05, 8'h43, 32'h0, 0, 0);
    get_reply("*0000000585^");
    u_host.send_req(8'h05, 8'h2A, 32'h00000063, 1, 0);
    get_reply("*0000006389^");
    check("reserved address refused", unit_addr_field, 8'h05);
    check("no storage use", wr_cnt + rd_cnt, 3);
  endtask

  task automatic t_jumper;
    do_reset(1);
    check("setup address", unit_addr_field, 8'h63);
    u_host.send_req(8'h63, 8'h43, 32'h0, 0, 0);
    get_reply("*0000006389^");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    do_reset(0);
    check("idle line", txd, 1'b1);
    check("reset address", unit_addr_field, 8'h01);
    t_write();
    t_query();
    t_bad();
    t_other();
    t_drop();
    t_addr();
    t_jumper();
    give_verdict();
  end

  // Ten frames of about 5000 cycles each fit well inside this
  initial begin
    repeat (95000) @(posedge mclk);
    fails++;
    give_verdict();
  end
endmodule
